// ==== include/gpio_strap_pkg.sv ====
// Purpose: shared constants and types for the strap and general pin block
// Assumes: 10 MHz mclk, 32-bit AXI4-Lite register access
// Notes: byte offsets are word aligned
// Operation
// - the strap pin pull-up is on while the pin reset is held low.
// - the pull-up turns off a few clocks after the pin reset rises, not at that edge.
// - the strap level is caught at the rising edge of the pin reset and picks the program memory.
// - the caught strap value reads back as a status bit of the first general input register.
// - after the pin reset the strap pin serves as a general pin, as the serial receive input or as the bank address bit output.
// - a low strap selects external program memory, which the board must then provide.
// - a high or open strap selects the internal ROM.
// - the bank address bit maps the upper half of a 128k memory into the 64k program space.
// - every general pin but the twelfth can be input, edge interrupt input or output.
// - the twelfth general pin is input or output only, with no edge interrupt.
// - the IR speed indicator output shows the current speed of the infrared link.
// - the infrared receive and transmit pins serve either as infrared lines or as UART lines.
// - the program memory chip enable is asserted except while the processor is in standby or the pin reset is asserted.
// - the program memory chip enable is held high while the pin reset is asserted.
package gpio_strap_pkg;
  localparam int NUM_GPIO = 12;
  localparam int STRAP_IDX = 5;
  localparam int NOEDGE_IDX = 11;
  localparam int ADDR_W = 8;
  localparam int SPEED_W = 2;

  localparam logic [ADDR_W-1:0] OFS_DIR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IN1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EDGE_EN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EDGE_POL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h1c;

  localparam int IN1_STRAP_BIT = 15;
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_BANK_BIT = 2;
  localparam int CTRL_IRUART_BIT = 3;
  localparam int CTRL_SPEED_LSB = 4;
  localparam int CTRL_W = 6;

  localparam logic [NUM_GPIO-1:0] DIR_RST = 12'h000;
  localparam logic [NUM_GPIO-1:0] OUT_RST = 12'h000;
  localparam logic [NUM_GPIO-1:0] EDGE_EN_RST = 12'h000;
  localparam logic [NUM_GPIO-1:0] EDGE_POL_RST = 12'hfff;
  localparam logic [NUM_GPIO-1:0] MASK_RST = 12'h000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic STRAP_RST = 1'b1;

  localparam int CLK_PERIOD_NS = 100;
  localparam int PULLUP_HOLD_NS = 400;
  localparam int PULLUP_HOLD_CYCLES = (PULLUP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FUNC_GPIO, FUNC_RX, FUNC_BANK} pin6_func_e;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_CTRL);
  endfunction

  // byte lanes applied to a register of up to 16 bits
  function automatic logic [15:0] mergeStrb(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction
endpackage

// ==== design/bit_sync.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: synchronous active-high reset
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1_r <= RST_VAL;
      stage2_r <= RST_VAL;
    end else begin
      stage1_r <= async;
      stage2_r <= stage1_r;
    end
  end

  assign synced = stage2_r;
endmodule // bit_sync

// ==== design/gpio_edge_detect.sv ====
// Purpose: per-pin edge detection for interrupt capable pins
// Assumes: levels already synchronised to mclk
// Notes: pulse lasts one cycle
`timescale 1ns/10ps
module gpio_edge_detect
  import gpio_strap_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] level,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] enable,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] risingSel,
  output logic [gpio_strap_pkg::NUM_GPIO-1:0] edgePulse
);
  logic [NUM_GPIO-1:0] prev_r;
  logic [NUM_GPIO-1:0] prev_nxt;

  always_comb begin
    prev_nxt = level;
    edgePulse = enable & ((risingSel & level & ~prev_r) | (~risingSel & ~level & prev_r));
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_r <= '0;
    end else begin
      prev_r <= prev_nxt;
    end
  end
endmodule // gpio_edge_detect

// ==== design/reset_strap_and_gpio_pins.sv ====
// Purpose: strap capture, pin functions and general pins behind AXI4-Lite
// Assumes: pin inputs asynchronous to mclk; cpuStandby and uart/ir data on mclk
// Notes: pin reset is sampled, so its effects lag the pin by three clocks or more
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module reset_strap_and_gpio_pins
  import gpio_strap_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [gpio_strap_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [gpio_strap_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic activeLowResetPin,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] gpioIn,
  output logic [gpio_strap_pkg::NUM_GPIO-1:0] gpioOut,
  output logic [gpio_strap_pkg::NUM_GPIO-1:0] gpioOe,
  output logic strapPullupEn,
  output logic extProgMemSel,
  input wire logic cpuStandby,
  output logic programMemChipEnableN,
  input wire logic irReceiveLine,
  output logic irTransmitLine,
  output logic [gpio_strap_pkg::SPEED_W-1:0] irSpeedIndicator,
  output logic uartRx,
  input wire logic uartTx,
  output logic irRxData,
  input wire logic irTxData,
  output logic interrupt
);
  import gpio_strap_pkg::*;

  logic rstPinSync;
  logic irRxSync;
  logic [NUM_GPIO-1:0] gpioSync;
  logic [NUM_GPIO-1:0] edgePulse;
  logic pinResetActive;
  logic releaseEdge;
  pin6_func_e pinFunc;

  // register file
  logic [NUM_GPIO-1:0] dir_r, dir_nxt;
  logic [NUM_GPIO-1:0] outReg_r, outReg_nxt;
  logic [NUM_GPIO-1:0] edgeEn_r, edgeEn_nxt;
  logic [NUM_GPIO-1:0] edgePol_r, edgePol_nxt;
  logic [NUM_GPIO-1:0] status_r, status_nxt;
  logic [NUM_GPIO-1:0] mask_r, mask_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;

  // bus state
  logic awHeld_r, awHeld_nxt;
  logic wHeld_r, wHeld_nxt;
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic doWrite;
  logic [NUM_GPIO-1:0] w1c;

  // strap and pin state
  logic rstPinPrev_r, rstPinPrev_nxt;
  logic strap_r, strap_nxt;
  logic [HOLD_CNT_W-1:0] holdCnt_r, holdCnt_nxt;
  logic pullup_r, pullup_nxt;
  logic [NUM_GPIO-1:0] gpioOut_r, gpioOut_nxt;
  logic [NUM_GPIO-1:0] gpioOe_r, gpioOe_nxt;
  logic chipEnN_r, chipEnN_nxt;
  logic irTx_r, irTx_nxt;
  logic uartRx_r, uartRx_nxt;
  logic irRxData_r, irRxData_nxt;
  logic extSel_r, extSel_nxt;
  logic irq_r, irq_nxt;

  // pin reset idles asserted until seen high
  bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
    .mclk(mclk),
    .reset(reset),
    .async(activeLowResetPin),
    .synced(rstPinSync)
  );

  bit_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_irrx_sync (
    .mclk(mclk),
    .reset(reset),
    .async(irReceiveLine),
    .synced(irRxSync)
  );

  bit_sync #(.WIDTH(NUM_GPIO), .RST_VAL(OUT_RST)) u_gpio_sync (
    .mclk(mclk),
    .reset(reset),
    .async(gpioIn),
    .synced(gpioSync)
  );

  gpio_edge_detect u_edge (
    .mclk(mclk),
    .reset(reset),
    .level(gpioSync),
    .enable(edgeEn_r & ~dir_r & {NUM_GPIO{~pinResetActive}}),
    .risingSel(edgePol_r),
    .edgePulse(edgePulse)
  );

  assign pinResetActive = ~rstPinSync;
  assign releaseEdge = rstPinSync & ~rstPinPrev_r;
  assign pinFunc = pin6_func_e'(ctrl_r[CTRL_FUNC_LSB +: 2]);

  // ---------------- bus slave ----------------
  assign awready = ~awHeld_r & ~bvalid_r;
  assign wready = ~wHeld_r & ~bvalid_r;
  assign arready = ~rvalid_r;
  assign doWrite = awHeld_r & wHeld_r & ~bvalid_r;

  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (awvalid && awready) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = wdata;
      wStrb_nxt = wstrb;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt = 32'h0000_0000;
      case (araddr)
        OFS_DIR: rdata_nxt[NUM_GPIO-1:0] = dir_r;
        OFS_OUT: rdata_nxt[NUM_GPIO-1:0] = outReg_r;
        OFS_IN1: begin
          rdata_nxt[NUM_GPIO-1:0] = gpioSync;
          rdata_nxt[IN1_STRAP_BIT] = strap_r;
        end
        OFS_EDGE_EN: rdata_nxt[NUM_GPIO-1:0] = edgeEn_r;
        OFS_EDGE_POL: rdata_nxt[NUM_GPIO-1:0] = edgePol_r;
        OFS_STATUS: rdata_nxt[NUM_GPIO-1:0] = status_r;
        OFS_MASK: rdata_nxt[NUM_GPIO-1:0] = mask_r;
        OFS_CTRL: rdata_nxt[CTRL_W-1:0] = ctrl_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ---------------- registers ----------------
  always_comb begin
    logic [15:0] m;
    m = 16'h0000;
    dir_nxt = dir_r;
    outReg_nxt = outReg_r;
    edgeEn_nxt = edgeEn_r;
    edgePol_nxt = edgePol_r;
    mask_nxt = mask_r;
    ctrl_nxt = ctrl_r;
    w1c = '0;
    if (doWrite) begin
      case (awAddr_r)
        OFS_DIR: begin
          m = mergeStrb({4'h0, dir_r}, wData_r, wStrb_r);
          dir_nxt = m[NUM_GPIO-1:0];
        end
        OFS_OUT: begin
          m = mergeStrb({4'h0, outReg_r}, wData_r, wStrb_r);
          outReg_nxt = m[NUM_GPIO-1:0];
        end
        OFS_EDGE_EN: begin
          m = mergeStrb({4'h0, edgeEn_r}, wData_r, wStrb_r);
          edgeEn_nxt = m[NUM_GPIO-1:0];
        end
        OFS_EDGE_POL: begin
          m = mergeStrb({4'h0, edgePol_r}, wData_r, wStrb_r);
          edgePol_nxt = m[NUM_GPIO-1:0];
        end
        OFS_STATUS: begin
          m = mergeStrb(16'h0000, wData_r, wStrb_r);
          w1c = m[NUM_GPIO-1:0];
        end
        OFS_MASK: begin
          m = mergeStrb({4'h0, mask_r}, wData_r, wStrb_r);
          mask_nxt = m[NUM_GPIO-1:0];
        end
        OFS_CTRL: begin
          m = mergeStrb({10'h000, ctrl_r}, wData_r, wStrb_r);
          ctrl_nxt = m[CTRL_W-1:0];
        end
        default: m = 16'h0000;
      endcase
    end
    edgeEn_nxt[NOEDGE_IDX] = 1'b0;
    // new edge beats a same-cycle clear
    status_nxt = (status_r & ~w1c) | edgePulse;
    irq_nxt = |(status_nxt & mask_r);
  end

  // ---------------- strap and pins ----------------
  always_comb begin
    rstPinPrev_nxt = rstPinSync;
    strap_nxt = strap_r;
    if (releaseEdge) begin
      strap_nxt = gpioSync[STRAP_IDX];
    end
    extSel_nxt = ~strap_nxt;
    // pull-up lingers so the strap level settles before the pin is reused
    holdCnt_nxt = holdCnt_r;
    if (pinResetActive) begin
      holdCnt_nxt = HOLD_CNT_W'(PULLUP_HOLD_CYCLES);
    end else if (holdCnt_r != '0) begin
      holdCnt_nxt = holdCnt_r - 1'b1;
    end
    pullup_nxt = pinResetActive | (holdCnt_nxt != '0);

    gpioOut_nxt = outReg_r;
    gpioOe_nxt = dir_r;
    case (pinFunc)
      FUNC_RX: gpioOe_nxt[STRAP_IDX] = 1'b0;
      FUNC_BANK: begin
        gpioOut_nxt[STRAP_IDX] = ctrl_r[CTRL_BANK_BIT];
        gpioOe_nxt[STRAP_IDX] = 1'b1;
      end
      default: gpioOe_nxt[STRAP_IDX] = dir_r[STRAP_IDX];
    endcase
    // no pin may fight the strap while it is sampled
    if (pinResetActive || holdCnt_r != '0) begin
      gpioOe_nxt = '0;
    end

    chipEnN_nxt = pinResetActive | cpuStandby;
    if (ctrl_r[CTRL_IRUART_BIT]) begin
      irTx_nxt = uartTx;
      irRxData_nxt = 1'b1;
    end else begin
      irTx_nxt = irTxData;
      irRxData_nxt = irRxSync;
    end
    if (pinFunc == FUNC_RX) begin
      uartRx_nxt = gpioSync[STRAP_IDX];
    end else if (ctrl_r[CTRL_IRUART_BIT]) begin
      uartRx_nxt = irRxSync;
    end else begin
      uartRx_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      dir_r <= DIR_RST;
      outReg_r <= OUT_RST;
      edgeEn_r <= EDGE_EN_RST;
      edgePol_r <= EDGE_POL_RST;
      status_r <= '0;
      mask_r <= MASK_RST;
      ctrl_r <= CTRL_RST;
      irq_r <= 1'b0;
      rstPinPrev_r <= 1'b0;
      strap_r <= STRAP_RST;
      extSel_r <= ~STRAP_RST;
      holdCnt_r <= HOLD_CNT_W'(PULLUP_HOLD_CYCLES);
      pullup_r <= 1'b1;
      gpioOut_r <= OUT_RST;
      gpioOe_r <= '0;
      chipEnN_r <= 1'b1;
      irTx_r <= 1'b1;
      uartRx_r <= 1'b1;
      irRxData_r <= 1'b1;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      dir_r <= dir_nxt;
      outReg_r <= outReg_nxt;
      edgeEn_r <= edgeEn_nxt;
      edgePol_r <= edgePol_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      ctrl_r <= ctrl_nxt;
      irq_r <= irq_nxt;
      rstPinPrev_r <= rstPinPrev_nxt;
      strap_r <= strap_nxt;
      extSel_r <= extSel_nxt;
      holdCnt_r <= holdCnt_nxt;
      pullup_r <= pullup_nxt;
      gpioOut_r <= gpioOut_nxt;
      gpioOe_r <= gpioOe_nxt;
      chipEnN_r <= chipEnN_nxt;
      irTx_r <= irTx_nxt;
      uartRx_r <= uartRx_nxt;
      irRxData_r <= irRxData_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign gpioOut = gpioOut_r;
  assign gpioOe = gpioOe_r;
  assign strapPullupEn = pullup_r;
  assign extProgMemSel = extSel_r;
  assign programMemChipEnableN = chipEnN_r;
  assign irTransmitLine = irTx_r;
  assign irSpeedIndicator = ctrl_r[CTRL_SPEED_LSB +: SPEED_W];
  assign uartRx = uartRx_r;
  assign irRxData = irRxData_r;
  assign interrupt = irq_r;
endmodule // reset_strap_and_gpio_pins

// ==== verification/gpio_strap_sva.sv ====
// Purpose: strap, pull-up, chip enable and pin function checks
// Assumes: one mclk domain, synchronous reset
// Notes: windows allow for the pin reset synchroniser
`timescale 1ns/10ps
module gpio_strap_checker
  import gpio_strap_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic activeLowResetPin,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] gpioIn,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] gpioOe,
  input wire logic strapPullupEn,
  input wire logic extProgMemSel,
  input wire logic cpuStandby,
  input wire logic programMemChipEnableN,
  input wire logic [gpio_strap_pkg::SPEED_W-1:0] irSpeedIndicator,
  input wire logic bvalid,
  input wire logic irTransmitLine,
  input wire logic uartTx,
  input wire logic irTxData
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // five low samples: long enough for the synchroniser to pass the pin reset
  sequence s_held; !activeLowResetPin[*5]; endsequence
  sequence s_release; s_held ##1 activeLowResetPin; endsequence
  sequence s_strap(logic v);
    (!activeLowResetPin && gpioIn[STRAP_IDX] == v)[*4] ##1 (activeLowResetPin && gpioIn[STRAP_IDX] == v)[*3];
  endsequence
  property p_pullOn; s_held |-> strapPullupEn; endproperty
  a_pullOn: assert property (p_pullOn) else $error("pull-up off in pin reset");
  property p_pullLate; s_release |-> strapPullupEn[*3] ##[1:8] !strapPullupEn; endproperty
  a_pullLate: assert property (p_pullLate) else $error("pull-up release timing");
  property p_capLow; s_strap(1'b0) |-> ##[0:4] extProgMemSel; endproperty
  a_capLow: assert property (p_capLow) else $error("low strap not external");
  property p_capHigh; s_strap(1'b1) |-> ##[0:4] !extProgMemSel; endproperty
  a_capHigh: assert property (p_capHigh) else $error("high strap not internal");
  property p_capKeep; activeLowResetPin[*8] |-> $stable(extProgMemSel); endproperty
  a_capKeep: assert property (p_capKeep) else $error("strap select moved");
  property p_noDrive; s_held |-> gpioOe == '0; endproperty
  a_noDrive: assert property (p_noDrive) else $error("pin driven in pin reset");
  property p_ceReset; s_held |-> programMemChipEnableN; endproperty
  a_ceReset: assert property (p_ceReset) else $error("chip enable low in pin reset");
  property p_ceRun; activeLowResetPin[*6] |=> programMemChipEnableN == $past(cpuStandby); endproperty
  a_ceRun: assert property (p_ceRun) else $error("chip enable vs standby");
  // speed field only moves with a completed register write
  property p_speed; !$rose(bvalid) |-> $stable(irSpeedIndicator); endproperty
  a_speed: assert property (p_speed) else $error("speed moved without write");
  property p_txSrc; $changed(irTransmitLine) |-> irTransmitLine == $past(uartTx) || irTransmitLine == $past(irTxData);
  endproperty
  a_txSrc: assert property (p_txSrc) else $error("transmit line source");
endmodule // gpio_strap_checker
bind reset_strap_and_gpio_pins gpio_strap_checker i_chk (.mclk, .reset, .activeLowResetPin, .gpioIn, .gpioOe,
  .strapPullupEn, .extProgMemSel, .cpuStandby, .programMemChipEnableN, .irSpeedIndicator, .bvalid, .irTransmitLine,
  .uartTx, .irTxData);

// ==== verification/board_strap_model.sv ====
// Purpose: board side of the pins: strap resistor, pin reset source, external drivers
// Assumes: bench sets strapLow and boardDrive after a clock edge
// Notes: strap pull-down beats the weak internal pull-up
`timescale 1ns/10ps
module board_strap_model
  import gpio_strap_pkg::*;
(
  input wire logic mclk,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] gpioOut,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] gpioOe,
  input wire logic strapPullupEn,
  input wire logic [gpio_strap_pkg::NUM_GPIO-1:0] boardDrive,
  input wire logic strapLow,
  output logic [gpio_strap_pkg::NUM_GPIO-1:0] gpioIn,
  output logic activeLowResetPin
);
  initial activeLowResetPin = 1'b0;

  // never shorter than the minimum pulse, whatever the caller asks
  task automatic pinReset(input int n);
    activeLowResetPin <= 1'b0;
    repeat (n < RESET_MIN_CYCLES ? RESET_MIN_CYCLES : n) @(posedge mclk);
    activeLowResetPin <= 1'b1;
  endtask

  always_comb begin
    for (int i = 0; i < NUM_GPIO; i++) begin
      if (gpioOe[i])
        gpioIn[i] = gpioOut[i];
      else if (i == STRAP_IDX && strapLow)
        gpioIn[i] = 1'b0;
      else if (i == STRAP_IDX && strapPullupEn)
        gpioIn[i] = 1'b1;
      else
        gpioIn[i] = boardDrive[i];
    end
  end
endmodule // board_strap_model

// ==== verification/testbench.sv ====
// Purpose: register and pin level tests of the strap and general pin block
// Assumes: outputs read right after an edge hold the values of the cycle before
// Notes: bus tasks wait without a cycle count; the watchdog ends hangs
`timescale 1ns/10ps
module testbench;
  import gpio_strap_pkg::*;
  logic mclk, reset, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic activeLowResetPin, strapPullupEn, extProgMemSel, cpuStandby, programMemChipEnableN, strapLow;
  logic irReceiveLine, irTransmitLine, uartRx, uartTx, irRxData, irTxData, interrupt;
  logic [NUM_GPIO-1:0] gpioIn, gpioOut, gpioOe, boardDrive;
  logic [SPEED_W-1:0] irSpeedIndicator;
  int n_fail = 0;
  int total_checks = 0;

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  reset_strap_and_gpio_pins i_dut (.*);
  board_strap_model i_board (.*);

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel released at its own handshake
    while (aw || w) begin
      @(posedge mclk);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end
    // bready stays up: lowering it here would clash with the raise of a back-to-back call
    do @(posedge mclk); while (!bvalid);
    chk(32'(bresp), 32'(er));
  endtask

  task automatic axiRead(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    chk(rdata, exp);
    chk(32'(rresp), 32'(er));
  endtask

  initial begin
    cyc(3000);
    n_fail++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, cpuStandby} = '0;
    {awaddr, araddr, wdata, wstrb, boardDrive} = '0;
    {irReceiveLine, uartTx, irTxData, strapLow} = '1;
    cyc(3);
    reset <= 1'b0;
    cyc(4);
    chk(32'(strapPullupEn), 32'h1);
    chk(32'(programMemChipEnableN), 32'h1);
    chk(32'(gpioOe), 32'h0);
    axiRead(OFS_IN1, 32'h8000, RESP_OKAY);
    i_board.pinReset(12);
    // past the synced release edge, so a pull-up dropped right there shows
    cyc(4);
    chk(32'(strapPullupEn), 32'h1);
    cyc(7);
    chk(32'(strapPullupEn), 32'h0);
    chk(32'(extProgMemSel), 32'h1);
    axiRead(OFS_IN1, 32'h0, RESP_OKAY);
    strapLow <= 1'b0;
    boardDrive <= 12'h020;
    cyc(4);
    axiRead(OFS_IN1, 32'h20, RESP_OKAY);
    chk(32'(extProgMemSel), 32'h1);
    boardDrive <= 12'h000;
    i_board.pinReset(12);
    cyc(10);
    chk(32'(extProgMemSel), 32'h0);
    axiRead(OFS_IN1, 32'h8000, RESP_OKAY);
    axiWrite(OFS_EDGE_EN, 32'hfff, RESP_OKAY);
    axiRead(OFS_EDGE_EN, 32'h7ff, RESP_OKAY);
    axiWrite(OFS_MASK, 32'hfff, RESP_OKAY);
    boardDrive <= 12'hfff;
    cyc(6);
    chk(32'(interrupt), 32'h1);
    axiRead(OFS_STATUS, 32'h7ff, RESP_OKAY);
    axiWrite(OFS_MASK, 32'h0, RESP_OKAY);
    cyc(3);
    chk(32'(interrupt), 32'h0);
    axiWrite(OFS_STATUS, 32'hfff, RESP_OKAY);
    axiRead(OFS_STATUS, 32'h0, RESP_OKAY);
    axiWrite(OFS_EDGE_POL, 32'h0, RESP_OKAY);
    axiWrite(OFS_MASK, 32'hfff, RESP_OKAY);
    boardDrive <= 12'h000;
    cyc(6);
    axiRead(OFS_STATUS, 32'h7ff, RESP_OKAY);
    chk(32'(interrupt), 32'h1);
    axiWrite(OFS_STATUS, 32'h7ff, RESP_OKAY);
    cyc(3);
    chk(32'(interrupt), 32'h0);
    axiWrite(OFS_DIR, 32'hfff, RESP_OKAY);
    axiWrite(OFS_OUT, 32'ha5a, RESP_OKAY);
    cyc(3);
    chk(32'(gpioOut), 32'ha5a);
    chk(32'(gpioOe), 32'hfff);
    axiRead(OFS_IN1, 32'h8a5a, RESP_OKAY);
    axiWrite(OFS_CTRL, 32'h36, RESP_OKAY);
    cyc(3);
    chk(32'(irSpeedIndicator), 32'h3);
    chk(32'({gpioOe[STRAP_IDX], gpioOut[STRAP_IDX]}), 32'h3);
    axiWrite(OFS_CTRL, 32'h2a, RESP_OKAY);
    irReceiveLine <= 1'b0;
    uartTx <= 1'b0;
    cyc(4);
    chk(32'(gpioOut[STRAP_IDX]), 32'h0);
    chk(32'(irSpeedIndicator), 32'h2);
    chk(32'({uartRx, irRxData, irTransmitLine}), 32'h2);
    axiWrite(OFS_CTRL, 32'h0, RESP_OKAY);
    uartTx <= 1'b1;
    irTxData <= 1'b0;
    cyc(4);
    chk(32'({irRxData, irTransmitLine}), 32'h0);
    // receive function: pin released although DIR says output, its level goes to the UART
    boardDrive <= 12'h020;
    axiWrite(OFS_CTRL, 32'h1, RESP_OKAY);
    cyc(4);
    chk(32'({gpioOe[STRAP_IDX], uartRx}), 32'h1);
    axiRead(8'h20, 32'h0, RESP_SLVERR);
    axiWrite(8'h22, 32'h1, RESP_SLVERR);
    cpuStandby <= 1'b1;
    cyc(3);
    chk(32'(programMemChipEnableN), 32'h1);
    cpuStandby <= 1'b0;
    cyc(3);
    chk(32'(programMemChipEnableN), 32'h0);
    give_verdict();
  end
endmodule // testbench
